/* File: usalu_consts.svh */
`ifndef USALU_CONSTS_SVH
`define USALU_CONSTS_SVH

`define USALU_DATA_W 32
`define USALU_HALF_W 16
`define USALU_BYTE_W 8
`define USALU_GE_W 4
`define USALU_HALF_LIMIT 17'h10000
`define USALU_BYTE_LIMIT 9'h100
`define USALU_MSB_POS 31
`define USALU_OP_W 4
`define USALU_DIV_STEPS 32
`define USALU_DIV_CNT_W 6
`define USALU_GE_RESET 4'h0

`endif

/* File: usalu_pkg.sv */
package usalu_pkg;

  typedef enum logic [3:0] {
    USALU_OP_NONE = 4'h0,
    USALU_OP_DUAL_HALF_ADD = 4'h1,
    USALU_OP_QUAD_BYTE_ADD = 4'h2,
    USALU_OP_EXCHANGE_ADD_SUB = 4'h3,
    USALU_OP_FIELD_EXTRACT_ZERO = 4'h4,
    USALU_OP_ALWAYS_UNDEFINED = 4'h5,
    USALU_OP_UNSIGNED_DIVIDE = 4'h6,
    USALU_OP_HALVING_DUAL_HALF_ADD = 4'h7,
    USALU_OP_HALVING_QUAD_BYTE_ADD = 4'h8
  } usalu_op_t;

  typedef enum logic [1:0] {
    USALU_ST_IDLE = 2'b00,
    USALU_ST_DIVIDE = 2'b01,
    USALU_ST_DONE = 2'b10
  } usalu_state_t;

endpackage : usalu_pkg

/* File: usalu_lanes.sv */
`include "usalu_consts.svh"

module usalu_lanes
  import usalu_pkg::*;
(
  input wire logic [31:0] opA,
  input wire logic [31:0] opB,
  input wire usalu_op_t opCode,
  output logic [31:0] laneResult,
  output logic [3:0] laneGe
);

  logic [16:0] halfSum [2];
  logic [8:0] byteSum [4];
  logic [16:0] xDiff;
  logic [16:0] xSum;
  logic [31:0] quadWrap;
  logic [31:0] quadHalf;
  logic [3:0] quadGe;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_half
      assign halfSum[gi] = {1'b0, opA[gi*16 +: 16]} + {1'b0, opB[gi*16 +: 16]};
    end
    for (gi = 0; gi < 4; gi++) begin : g_byte
      assign byteSum[gi] = {1'b0, opA[gi*8 +: 8]} + {1'b0, opB[gi*8 +: 8]};
      assign quadWrap[gi*8 +: 8] = byteSum[gi][7:0];
      assign quadHalf[gi*8 +: 8] = byteSum[gi][8:1];
      assign quadGe[gi] = (byteSum[gi] > `USALU_BYTE_LIMIT);
    end
  endgenerate

  assign xDiff = {1'b0, opA[15:0]} - {1'b0, opB[31:16]};
  assign xSum = {1'b0, opA[31:16]} + {1'b0, opB[15:0]};

  always_comb begin
    laneResult = 32'h0;
    laneGe = `USALU_GE_RESET;
    case (opCode)
      USALU_OP_DUAL_HALF_ADD: begin
        laneResult = {halfSum[1][15:0], halfSum[0][15:0]};
        laneGe = {{2{halfSum[1] >= `USALU_HALF_LIMIT}},
                  {2{halfSum[0] >= `USALU_HALF_LIMIT}}};
      end
      USALU_OP_QUAD_BYTE_ADD: begin
        laneResult = quadWrap;
        laneGe = quadGe;
      end
      USALU_OP_EXCHANGE_ADD_SUB: begin
        laneResult = {xSum[15:0], xDiff[15:0]};
        laneGe = {{2{xSum >= `USALU_HALF_LIMIT}}, {2{~xDiff[16]}}};
      end
      USALU_OP_HALVING_DUAL_HALF_ADD: begin
        laneResult = {halfSum[1][16:1], halfSum[0][16:1]};
      end
      USALU_OP_HALVING_QUAD_BYTE_ADD: begin
        laneResult = quadHalf;
      end
      default: begin
        laneResult = 32'h0;
      end
    endcase
  end

endmodule : usalu_lanes

/* File: usalu_divider.sv */
`include "usalu_consts.svh"

module usalu_divider
  import usalu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  output logic busy,
  output logic done,
  output logic [31:0] quotient
);

  logic [31:0] quot_q;
  logic [31:0] rem_q;
  logic [31:0] dvsr_q;
  logic [5:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic [32:0] trial;

  assign trial = {rem_q, quot_q[31]} - {1'b0, dvsr_q};

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= 6'h0;
      quot_q <= 32'h0;
      rem_q <= 32'h0;
      dvsr_q <= 32'h0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= 6'(`USALU_DIV_STEPS);
        quot_q <= dividend;
        rem_q <= 32'h0;
        dvsr_q <= divisor;
      end else if (busy_q) begin
        // restoring step, truncating quotient
        if (!trial[32]) begin
          rem_q <= trial[31:0];
          quot_q <= {quot_q[30:0], 1'b1};
        end else begin
          rem_q <= {rem_q[30:0], quot_q[31]};
          quot_q <= {quot_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h1;
        if (cnt_q == 6'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign quotient = quot_q;

endmodule : usalu_divider

/* File: usalu_core.sv */
// Functional notes
// - dual halfword add writes low 16 bits of each lane sum
// - dual halfword add flag pair 11 when lane sum at least 0x10000
// - quad byte add writes low eight bits of each byte lane sum
// - quad byte add flag bit set when lane sum exceeds 0x100
// - exchange op: low = a.lo - b.hi, high = a.hi + b.lo
// - exchange flags: low pair on non-negative diff, high pair on sum carry
// - field extract writes selected adjacent bits zero-extended to 32 bits
// - field start 0..31, width 1..32-start; overflowing fields are unpredictable
// - always-undefined op raises undefined exception when condition passes
// - always-undefined immediate, 8 or 16 bits, ignored by hardware
// - unsigned divide of two 32-bit values, quotient truncated
// - zero divisor traps if enabled, else writes zero
// - unsigned divide leaves condition flags unchanged
// - halving dual halfword add writes sum bits 16:1, flags untouched
// - halving quad byte add writes sum bits 8:1
`include "usalu_consts.svh"

module usalu_core
  import usalu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic issueValid,
  input wire usalu_op_t issueOp,
  input wire logic condPass,
  input wire logic [31:0] operandN,
  input wire logic [31:0] operandM,
  input wire logic [4:0] fieldLsb,
  input wire logic [4:0] fieldWidthLessOne,
  input wire logic [15:0] undefImm,
  input wire logic zeroDivTrapEnable,
  input wire logic [3:0] nzcvIn,
  output logic issueReady,
  output logic resultValid,
  output logic [31:0] resultData,
  output logic resultWrite,
  output logic geWrite,
  output logic [3:0] greaterEqualFlags,
  output logic [3:0] nzcvOut,
  output logic undefinedException,
  output logic usageFaultException
);

  usalu_state_t state_q;
  logic [31:0] laneResult;
  logic [3:0] laneGe;
  logic divStart;
  logic divBusy;
  logic divDone;
  logic [31:0] divQuot;
  logic [31:0] fieldShift;
  logic [31:0] fieldMask;
  logic [5:0] fieldMsb;
  logic [31:0] resultData_q;
  logic resultValid_q;
  logic resultWrite_q;
  logic geWrite_q;
  logic [3:0] ge_q;
  logic [3:0] nzcv_q;
  logic undef_q;
  logic usage_q;
  logic accept;
  logic isLane;
  logic isGeOp;
  logic unusedImm;

  usalu_lanes u_lanes (
    .opA(operandN),
    .opB(operandM),
    .opCode(issueOp),
    .laneResult(laneResult),
    .laneGe(laneGe)
  );

  usalu_divider u_div (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(divStart),
    .dividend(operandN),
    .divisor(operandM),
    .busy(divBusy),
    .done(divDone),
    .quotient(divQuot)
  );

  assign issueReady = (state_q == USALU_ST_IDLE);
  assign accept = issueValid && issueReady;
  assign unusedImm = ^undefImm;
  assign isGeOp = (issueOp == USALU_OP_DUAL_HALF_ADD) ||
                  (issueOp == USALU_OP_QUAD_BYTE_ADD) ||
                  (issueOp == USALU_OP_EXCHANGE_ADD_SUB);
  assign isLane = isGeOp || (issueOp == USALU_OP_HALVING_DUAL_HALF_ADD) ||
                  (issueOp == USALU_OP_HALVING_QUAD_BYTE_ADD);
  assign divStart = accept && condPass && (issueOp == USALU_OP_UNSIGNED_DIVIDE) &&
                    (operandM != 32'h0);

  // field extract, overflowing fields give the truncated field
  assign fieldMsb = {1'b0, fieldLsb} + {1'b0, fieldWidthLessOne};
  assign fieldShift = operandN >> fieldLsb;
  assign fieldMask = (fieldWidthLessOne == 5'h1f) ? 32'hffffffff :
                     ((32'h1 << (fieldWidthLessOne + 5'h1)) - 32'h1);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= USALU_ST_IDLE;
    end else begin
      case (state_q)
        USALU_ST_IDLE: begin
          if (divStart) begin
            state_q <= USALU_ST_DIVIDE;
          end
        end
        USALU_ST_DIVIDE: begin
          if (divDone) begin
            state_q <= USALU_ST_IDLE;
          end
        end
        default: begin
          state_q <= USALU_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      resultValid_q <= 1'b0;
      resultWrite_q <= 1'b0;
      geWrite_q <= 1'b0;
      resultData_q <= 32'h0;
      undef_q <= 1'b0;
      usage_q <= 1'b0;
    end else begin
      resultValid_q <= 1'b0;
      resultWrite_q <= 1'b0;
      geWrite_q <= 1'b0;
      undef_q <= 1'b0;
      usage_q <= 1'b0;
      if (state_q == USALU_ST_DIVIDE && divDone) begin
        resultValid_q <= 1'b1;
        resultWrite_q <= 1'b1;
        resultData_q <= divQuot;
      end else if (accept && !divStart) begin
        resultValid_q <= 1'b1;
        if (condPass) begin
          if (isLane) begin
            resultWrite_q <= 1'b1;
            resultData_q <= laneResult;
            geWrite_q <= isGeOp;
          end else if (issueOp == USALU_OP_FIELD_EXTRACT_ZERO) begin
            resultWrite_q <= 1'b1;
            resultData_q <= fieldShift & fieldMask;
          end else if (issueOp == USALU_OP_ALWAYS_UNDEFINED) begin
            undef_q <= 1'b1;
          end else if (issueOp == USALU_OP_UNSIGNED_DIVIDE) begin
            if (zeroDivTrapEnable) begin
              usage_q <= 1'b1;
            end else begin
              resultWrite_q <= 1'b1;
              resultData_q <= 32'h0;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ge_q <= `USALU_GE_RESET;
    end else if (accept && condPass && isGeOp) begin
      ge_q <= laneGe;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      nzcv_q <= 4'h0;
    end else begin
      nzcv_q <= nzcvIn;
    end
  end

  assign resultValid = resultValid_q;
  assign resultWrite = resultWrite_q;
  assign resultData = resultData_q;
  assign geWrite = geWrite_q;
  assign greaterEqualFlags = ge_q;
  assign nzcvOut = nzcv_q;
  assign undefinedException = undef_q;
  assign usageFaultException = usage_q;

  sequence divIssued_s;
    divStart;
  endsequence

  sequence divFinished_s;
    resultValid && resultWrite;
  endsequence

  div_latency_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    divIssued_s |-> ##34 divFinished_s)
    else $error("divide result not after 34 cycles");

  div_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    divStart |-> ##34 (resultData == $past(operandN, 34) / $past(operandM, 34)))
    else $error("divide quotient wrong");

  zero_trap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_UNSIGNED_DIVIDE && operandM == 32'h0)
    |=> (usageFaultException == $past(zeroDivTrapEnable)) &&
        (resultWrite == !$past(zeroDivTrapEnable)) && (!resultWrite || resultData == 32'h0))
    else $error("zero divide handling wrong");

  undef_raise_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_ALWAYS_UNDEFINED) |=>
    undefinedException && !resultWrite)
    else $error("undefined op did not trap");

  cond_fail_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && !condPass) |=> !resultWrite && !geWrite && $stable(greaterEqualFlags) &&
    !undefinedException && !usageFaultException)
    else $error("failed condition changed state");

  dual_half_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_DUAL_HALF_ADD) |=>
    resultData == {$past(operandN[31:16]) + $past(operandM[31:16]),
                   $past(operandN[15:0]) + $past(operandM[15:0])})
    else $error("dual halfword sum wrong");

  dual_ge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_DUAL_HALF_ADD) |=>
    greaterEqualFlags[0] == ({1'b0, $past(operandN[15:0])} + $past(operandM[15:0]) >= 17'h10000))
    else $error("dual halfword flag wrong");

  halving_ge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_HALVING_DUAL_HALF_ADD) |=>
    $stable(greaterEqualFlags) && !geWrite)
    else $error("halving add touched flags");

  extract_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_FIELD_EXTRACT_ZERO && fieldMsb <= 6'd31)
    |=> (resultData >> ($past(fieldWidthLessOne) + 6'h1)) == 32'h0)
    else $error("extract not zero extended");

  quad_byte_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_QUAD_BYTE_ADD) |=>
    resultData == {$past(operandN[31:24]) + $past(operandM[31:24]),
                   $past(operandN[23:16]) + $past(operandM[23:16]),
                   $past(operandN[15:8]) + $past(operandM[15:8]),
                   $past(operandN[7:0]) + $past(operandM[7:0])})
    else $error("quad byte sum wrong");

  quad_ge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_QUAD_BYTE_ADD) |=>
    greaterEqualFlags[0] == (({1'b0, $past(operandN[7:0])} + $past(operandM[7:0])) > 9'h100) &&
    greaterEqualFlags[3] == (({1'b0, $past(operandN[31:24])} + $past(operandM[31:24])) > 9'h100))
    else $error("quad byte flag wrong");

  exchange_sum_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_EXCHANGE_ADD_SUB) |=>
    resultData == {$past(operandN[31:16]) + $past(operandM[15:0]),
                   $past(operandN[15:0]) - $past(operandM[31:16])})
    else $error("exchange result wrong");

  exchange_ge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_EXCHANGE_ADD_SUB) |=>
    greaterEqualFlags[1:0] == {2{$past(operandN[15:0]) >= $past(operandM[31:16])}} &&
    greaterEqualFlags[3:2] ==
      {2{({1'b0, $past(operandN[31:16])} + $past(operandM[15:0])) >= 17'h10000}})
    else $error("exchange flags wrong");

  halving_dual_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_HALVING_DUAL_HALF_ADD) |=>
    resultData[31:16] == 16'(({1'b0, $past(operandN[31:16])} + $past(operandM[31:16])) >> 1))
    else $error("halving halfword sum wrong");

  halving_quad_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_HALVING_QUAD_BYTE_ADD) |=>
    resultData[7:0] == 8'(({1'b0, $past(operandN[7:0])} + $past(operandM[7:0])) >> 1) &&
    resultData[31:24] == 8'(({1'b0, $past(operandN[31:24])} + $past(operandM[31:24])) >> 1))
    else $error("halving byte sum wrong");

  imm_ignored_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && condPass && issueOp == USALU_OP_ALWAYS_UNDEFINED && unusedImm) |=>
    undefinedException && !resultWrite && !geWrite)
    else $error("undefined op depends on immediate");

  ge_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    accept |=> geWrite == ($past(condPass) && $past(isGeOp)))
    else $error("flag write on wrong op");

  busy_refuse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    divBusy |-> !issueReady)
    else $error("issue accepted while dividing");

  ready_back_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    divDone |=> issueReady && resultValid)
    else $error("divider did not release issue");

  cond_div_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (accept && !condPass && issueOp == USALU_OP_UNSIGNED_DIVIDE) |=>
    issueReady && resultValid && !resultWrite)
    else $error("failed divide started divider");

endmodule : usalu_core

/* File: usalu_regfile_model.sv */
module usalu_regfile_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic resultWrite,
  input wire logic [31:0] resultData,
  input wire logic geWrite,
  input wire logic [3:0] greaterEqualFlags,
  output logic [31:0] destQ,
  output logic [3:0] geQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // destination is always a general register, never stack pointer or pc
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      destQ <= 32'h0;
    end else if (resultWrite) begin
      destQ <= resultData;
    end
  end
  // flags copy moves only on a flag write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      geQ <= 4'h0;
    end else if (geWrite) begin
      geQ <= greaterEqualFlags;
    end
  end
endmodule : usalu_regfile_model

/* File: usalu_core_test.sv */
module usalu_core_test
  import usalu_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic issueValid = 1'b0;
  usalu_op_t issueOp = USALU_OP_NONE;
  logic condPass = 1'b1;
  logic [31:0] operandN = 32'h0;
  logic [31:0] operandM = 32'h0;
  logic [4:0] fieldLsb = 5'h0;
  logic [4:0] fieldWidthLessOne = 5'h0;
  logic [15:0] undefImm = 16'h0;
  logic zeroDivTrapEnable = 1'b0;
  logic [3:0] nzcvIn = 4'h0;
  logic issueReady, resultValid, resultWrite, geWrite, undefinedException, usageFaultException;
  logic [31:0] resultData, destQ, lastDest;
  logic [3:0] greaterEqualFlags, nzcvOut, geQ, geExp;
  logic [4:0] lsbV = 5'h0;
  logic [4:0] wloV = 5'h0;
  logic [15:0] immV = 16'h0;
  logic trapV = 1'b0;
  logic condV = 1'b1;
  logic [3:0] nzcvV = 4'h9;
  int fails = 0;
  int compares = 0;

  always #12.5 ref_clk = ~ref_clk;

  usalu_core u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .issueValid(issueValid),
    .issueOp(issueOp), .condPass(condPass), .operandN(operandN), .operandM(operandM),
    .fieldLsb(fieldLsb), .fieldWidthLessOne(fieldWidthLessOne), .undefImm(undefImm),
    .zeroDivTrapEnable(zeroDivTrapEnable), .nzcvIn(nzcvIn), .issueReady(issueReady),
    .resultValid(resultValid), .resultData(resultData), .resultWrite(resultWrite),
    .geWrite(geWrite), .greaterEqualFlags(greaterEqualFlags), .nzcvOut(nzcvOut),
    .undefinedException(undefinedException), .usageFaultException(usageFaultException));

  usalu_regfile_model u_model (.ref_clk(ref_clk), .reset_n(reset_n),
    .resultWrite(resultWrite), .resultData(resultData), .geWrite(geWrite),
    .greaterEqualFlags(greaterEqualFlags), .destQ(destQ), .geQ(geQ));

  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_bit

  task automatic run_op(input usalu_op_t op, input logic [31:0] n, input logic [31:0] m,
    input logic [31:0] expData, input logic [3:0] expGe);
    int cnt;
    logic isDiv, geWr, undef, fault, wr;
    isDiv = op == USALU_OP_UNSIGNED_DIVIDE && m != 32'h0 && condV;
    geWr = condV && (op == USALU_OP_DUAL_HALF_ADD || op == USALU_OP_QUAD_BYTE_ADD
      || op == USALU_OP_EXCHANGE_ADD_SUB);
    undef = condV && op == USALU_OP_ALWAYS_UNDEFINED;
    fault = condV && op == USALU_OP_UNSIGNED_DIVIDE && m == 32'h0 && trapV;
    wr = condV && !undef && !fault;
    @(negedge ref_clk);
    issueValid = 1'b1;
    issueOp = op;
    operandN = n;
    operandM = m;
    condPass = condV;
    fieldLsb = lsbV;
    fieldWidthLessOne = wloV;
    undefImm = immV;
    zeroDivTrapEnable = trapV;
    nzcvIn = nzcvV;
    chk_bit(issueReady, 1'b1, "ready");
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (cnt == 1) begin
        chk_word(destQ, lastDest, "model dest");
        chk_word({28'h0, geQ}, {28'h0, geExp}, "model ge");
        if (isDiv) chk_bit(issueReady, 1'b0, "refuse");
      end
    end while (resultValid !== 1'b1 && cnt < 40);
    if (resultValid !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    chk_word(32'(cnt), isDiv ? 32'd34 : 32'd1, "latency");
    @(negedge ref_clk);
    issueValid = 1'b0;
    if (geWr) geExp = expGe;
    if (wr) lastDest = expData;
    chk_bit(resultWrite, wr, "write");
    chk_bit(geWrite, geWr, "ge write");
    chk_bit(undefinedException, undef, "undef");
    chk_bit(usageFaultException, fault, "fault");
    if (wr) chk_word(resultData, expData, "data");
    chk_word({28'h0, greaterEqualFlags}, {28'h0, geExp}, "ge");
    chk_word({28'h0, nzcvOut}, {28'h0, nzcvV}, "nzcv");
  endtask : run_op

  task automatic lane_ops();
    run_op(USALU_OP_DUAL_HALF_ADD, 32'h1234_ffff, 32'h0001_0001, 32'h1235_0000, 4'h3);
    nzcvV = 4'ha;
    run_op(USALU_OP_QUAD_BYTE_ADD, 32'h8081_ff01, 32'h8080_0201, 32'h0001_0102, 4'h6);
    run_op(USALU_OP_EXCHANGE_ADD_SUB, 32'h0001_0003, 32'h0005_0002, 32'h0003_fffe, 4'h0);
    run_op(USALU_OP_EXCHANGE_ADD_SUB, 32'hffff_0005, 32'h0001_0007, 32'h0006_0004, 4'hf);
    run_op(USALU_OP_HALVING_DUAL_HALF_ADD, 32'hffff_0001, 32'h0001_0002, 32'h8000_0001, 4'h0);
    run_op(USALU_OP_HALVING_QUAD_BYTE_ADD, 32'hff01_0203, 32'hff00_0401, 32'hff00_0302, 4'h0);
  endtask : lane_ops

  task automatic field_case(input logic [4:0] lsb, input logic [4:0] wlo, input logic [31:0] e);
    lsbV = lsb;
    wloV = wlo;
    run_op(USALU_OP_FIELD_EXTRACT_ZERO, 32'hdead_beef, 32'h0, e, 4'h0);
  endtask : field_case

  task automatic extract_ops();
    field_case(5'h1f, 5'h00, 32'h0000_0001);
    field_case(5'h00, 5'h1f, 32'hdead_beef);
    field_case(5'h04, 5'h07, 32'h0000_00ee);
    field_case(5'h08, 5'h0f, 32'h0000_adbe);
  endtask : extract_ops

  task automatic undef_ops();
    immV = 16'h00ff;
    run_op(USALU_OP_ALWAYS_UNDEFINED, 32'h1, 32'h2, 32'h0, 4'h0);
    immV = 16'hfffe;
    run_op(USALU_OP_ALWAYS_UNDEFINED, 32'h1, 32'h2, 32'h0, 4'h0);
  endtask : undef_ops

  task automatic divide_ops();
    nzcvV = 4'h5;
    run_op(USALU_OP_UNSIGNED_DIVIDE, 32'h64, 32'h7, 32'he, 4'h0);
    run_op(USALU_OP_UNSIGNED_DIVIDE, 32'hffff_ffff, 32'h1, 32'hffff_ffff, 4'h0);
    run_op(USALU_OP_UNSIGNED_DIVIDE, 32'hffff_fffe, 32'hffff_ffff, 32'h0, 4'h0);
    run_op(USALU_OP_UNSIGNED_DIVIDE, 32'h55, 32'h0, 32'h0, 4'h0);
    trapV = 1'b1;
    run_op(USALU_OP_UNSIGNED_DIVIDE, 32'h55, 32'h0, 32'h0, 4'h0);
  endtask : divide_ops

  task automatic cond_fail_ops();
    condV = 1'b0;
    run_op(USALU_OP_DUAL_HALF_ADD, 32'hffff_ffff, 32'h0001_0001, 32'h0, 4'h0);
    run_op(USALU_OP_UNSIGNED_DIVIDE, 32'h55, 32'h0, 32'h0, 4'h0);
    run_op(USALU_OP_ALWAYS_UNDEFINED, 32'h1, 32'h2, 32'h0, 4'h0);
    run_op(USALU_OP_UNSIGNED_DIVIDE, 32'h64, 32'h7, 32'h0, 4'h0);
    condV = 1'b1;
    trapV = 1'b0;
    run_op(USALU_OP_QUAD_BYTE_ADD, 32'h0101_0101, 32'hffff_ffff, 32'h0, 4'h0);
  endtask : cond_fail_ops

  initial begin
    lastDest = 32'h0;
    geExp = 4'h0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    chk_bit(issueReady, 1'b1, "reset ready");
    chk_bit(resultValid, 1'b0, "reset valid");
    lane_ops();
    extract_ops();
    undef_ops();
    divide_ops();
    cond_fail_ops();
    report_and_stop();
  end
endmodule : usalu_core_test
